/* hw/dsb_debug_ctl.sv */
`timescale 1ns/100ps
// Function
// - Status register reached only by serial commands
// - Permit bit gates halt; reset clears it
// - Active flag reads 1 while halted
// - Breakpoint enable off: no breakpoint, except a pending tag can still fire in the first cycle
// - Force select: halt at next boundary
// - Tag select: halt when tagged opcode ends
// - Bit 3 selects comm clock, default 0
// - Wait-stop flag shows wait/stop or forced exit
// - Background command forces exit from wait/stop
// - Failure flag set on wait/stop conflict
// - Data valid failure flag always zero
// - Breakpoint address only via breakpoint commands
// - Permit write ignored while halted; flags read-only
// - Breakpoint without permit runs software interrupt
module dsb_debug_ctl (
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    input  wire dsb_pkg::dsb_cmd_s cmd_in,
    input  wire dsb_pkg::dsb_cpu_s cpu_in,
    output dsb_pkg::dsb_rsp_s      rsp_out,
    output logic                   halt_req_out,
    output logic                   swi_req_out,
    output logic                   wake_out,
    output logic                   comm_clock_select_out
);
    import dsb_pkg::*;

    // ***************************************************************
    // Control and status storage
    // ***************************************************************
    logic        background_permit_reg;
    logic        breakpoint_enable_reg;
    logic        force_tag_select_reg;
    logic        comm_clock_select_reg;
    logic        wait_stop_failure_reg;
    logic        woke_from_wait_reg;
    logic [15:0] debug_breakpoint_address_reg;
    dsb_state_e  state_reg;
    dsb_state_e  state_next;
    logic        force_req;
    logic        tag_hit;
    logic        bkpt_event;
    logic        bg_cmd;
    logic        halted;
    logic [7:0]  debug_status_control;
    logic        tag_pending_reg;
    logic        wr_ctrl;
    logic        wr_bkpt;
    logic        rd_stat;
    logic        rd_bkpt;

    // ***************************************************************
    // Command decode
    // ***************************************************************
    // Compares the command field of the serial port with one code.
    function automatic logic cmd_is(input dsb_cmd_s c, input dsb_cmd_e code);
        return c.cmd == code;
    endfunction

    assign halted  = (state_reg == DSB_HALT);
    assign bg_cmd  = cmd_is(cmd_in, DSB_CMD_BACKGROUND);
    assign wr_ctrl = cmd_is(cmd_in, DSB_CMD_WRITE_CTRL);
    assign wr_bkpt = cmd_is(cmd_in, DSB_CMD_BREAKPOINT_WRITE_COMMAND);
    assign rd_stat = cmd_is(cmd_in, DSB_CMD_READ_STAT);
    assign rd_bkpt = cmd_is(cmd_in, DSB_CMD_BREAKPOINT_READ_COMMAND);

    // Control bits change only through the serial control write.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            background_permit_reg <= CTRL_RESET[BIT_PERMIT];
            breakpoint_enable_reg <= CTRL_RESET[BIT_BKPT_EN];
            force_tag_select_reg  <= CTRL_RESET[BIT_FORCE_TAG];
            comm_clock_select_reg <= CTRL_RESET[BIT_CLK_SEL];
        end else if (wr_ctrl) begin
            if (!halted) begin
                background_permit_reg <= cmd_in.data[BIT_PERMIT];
            end
            breakpoint_enable_reg <= cmd_in.data[BIT_BKPT_EN];
            force_tag_select_reg  <= cmd_in.data[BIT_FORCE_TAG];
            comm_clock_select_reg <= cmd_in.data[BIT_CLK_SEL];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            debug_breakpoint_address_reg <= BKPT_RESET;
        end else if (wr_bkpt) begin
            debug_breakpoint_address_reg <= cmd_in.data;
        end
    end

    // ***************************************************************
    // Breakpoint
    // ***************************************************************
    dsb_bkpt_match u_match (
        .sys_clk_in      (sys_clk_in),
        .rst_n_in        (rst_n_in),
        .enable_in       (breakpoint_enable_reg),
        .force_sel_in    (force_tag_select_reg),
        .match_addr_in   (debug_breakpoint_address_reg),
        .cpu_addr_in     (cpu_in.addr),
        .opcode_fetch_in (cpu_in.opcode_fetch),
        .boundary_in     (cpu_in.inst_boundary),
        .halted_in       (halted),
        .force_req_out   (force_req),
        .tag_out         (tag_hit)
    );

    // A tagged fetch is remembered until the opcode leaves the queue end.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || !breakpoint_enable_reg || force_tag_select_reg) begin
            tag_pending_reg <= 1'b0;
        end else if (tag_hit) begin
            tag_pending_reg <= 1'b1;
        end else if (cpu_in.tagged_at_end) begin
            tag_pending_reg <= 1'b0;
        end
    end

    // A tagged opcode reaching the queue end halts instead of executing.
    assign bkpt_event = force_req || (cpu_in.tagged_at_end && tag_pending_reg);

    // ***************************************************************
    // Run state
    // ***************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DSB_RUN: begin
                if (background_permit_reg && (bkpt_event || bg_cmd)) begin
                    state_next = DSB_HALT;
                end else if (cpu_in.wait_stop) begin
                    state_next = DSB_STOP;
                end
            end
            DSB_STOP: begin
                if (background_permit_reg && bg_cmd) begin
                    state_next = DSB_HALT;
                end else if (!cpu_in.wait_stop) begin
                    state_next = DSB_RUN;
                end
            end
            DSB_HALT: begin
                if (cpu_in.resume) begin
                    state_next = DSB_RUN;
                end
            end
            default: state_next = DSB_RUN;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_reg <= DSB_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Remembers that the halt was entered out of wait or stop.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            woke_from_wait_reg <= 1'b0;
        end else if (state_reg == DSB_STOP && state_next == DSB_HALT) begin
            woke_from_wait_reg <= 1'b1;
        end else if (state_next != DSB_HALT) begin
            woke_from_wait_reg <= 1'b0;
        end
    end

    // Sticky failure flag; a new conflict wins over the clear on resume from halt.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wait_stop_failure_reg <= 1'b0;
        end else if (cpu_in.mem_cmd_conflict) begin
            wait_stop_failure_reg <= 1'b1;
        end else if (halted && cpu_in.resume) begin
            wait_stop_failure_reg <= 1'b0;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    always_comb begin
        debug_status_control                = 8'h00;
        debug_status_control[BIT_PERMIT]    = background_permit_reg;
        debug_status_control[BIT_ACTIVE]    = halted;
        debug_status_control[BIT_BKPT_EN]   = breakpoint_enable_reg;
        debug_status_control[BIT_FORCE_TAG] = force_tag_select_reg;
        debug_status_control[BIT_CLK_SEL]   = comm_clock_select_reg;
        debug_status_control[BIT_WAIT_STOP] = (state_reg == DSB_STOP) || woke_from_wait_reg;
        debug_status_control[BIT_WS_FAIL]   = wait_stop_failure_reg;
        debug_status_control[BIT_DV_FAIL]   = 1'b0;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rsp_out <= '0;
        end else begin
            rsp_out.valid <= rd_stat || rd_bkpt;
            if (rd_bkpt) begin
                rsp_out.data <= debug_breakpoint_address_reg;
            end else if (rd_stat) begin
                rsp_out.data <= {8'h00, debug_status_control};
            end else begin
                rsp_out.data <= 16'h0000;
            end
        end
    end

    assign halt_req_out          = (state_reg != DSB_HALT) && (state_next == DSB_HALT);
    assign swi_req_out           = !background_permit_reg && bkpt_event
                                   && (state_reg == DSB_RUN);
    assign wake_out              = (state_reg == DSB_STOP) && (state_next == DSB_HALT);
    assign comm_clock_select_out = comm_clock_select_reg;

    // ***************************************************************
    // Checks
    // ***************************************************************
    permit_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        halted |=> $stable(background_permit_reg) || !$past(halted))
        else $error("permit changed while halted");
    active_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        halt_req_out |=> debug_status_control[BIT_ACTIVE])
        else $error("active flag missing after halt");
    no_permit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (!background_permit_reg && state_reg != DSB_HALT) |=> state_reg != DSB_HALT)
        else $error("halt without permit");
    bkpt_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !breakpoint_enable_reg |-> !bkpt_event)
        else $error("breakpoint while disabled");
    swi_path_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        swi_req_out |=> state_reg != DSB_HALT)
        else $error("halt on unpermitted breakpoint");
    dvf_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !debug_status_control[BIT_DV_FAIL])
        else $error("data valid flag set");
    wsf_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        cpu_in.mem_cmd_conflict |=> wait_stop_failure_reg)
        else $error("failure flag lost");
    wake_ws_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        wake_out |=> halted && debug_status_control[BIT_WAIT_STOP])
        else $error("wake not reported");
    bkpt_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_bkpt ##1 !wr_bkpt ##1 rd_bkpt |=> rsp_out.data == $past(cmd_in.data, 3))
        else $error("breakpoint readback");
    rsp_valid_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (rd_stat || rd_bkpt) |=> rsp_out.valid)
        else $error("read answer missing");
    rsp_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !(rd_stat || rd_bkpt) |=> !rsp_out.valid && rsp_out.data == 16'h0000)
        else $error("answer without read");
    status_high_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        rd_stat |=> rsp_out.data[15:8] == 8'h00)
        else $error("status upper byte not zero");
    status_act_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        rd_stat |=> rsp_out.data[BIT_ACTIVE] == $past(halted))
        else $error("status read lost active flag");
    bkpt_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_bkpt |=> debug_breakpoint_address_reg == $past(cmd_in.data))
        else $error("breakpoint write lost");
    ctrl_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_ctrl |=> comm_clock_select_reg == $past(cmd_in.data[BIT_CLK_SEL]))
        else $error("clock select write lost");
    bkpt_cfg_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_ctrl |=> breakpoint_enable_reg == $past(cmd_in.data[BIT_BKPT_EN]))
        else $error("breakpoint enable write lost");
    permit_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_ctrl && !halted |=> background_permit_reg == $past(cmd_in.data[BIT_PERMIT]))
        else $error("permit write lost");
    resume_run_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        halted && cpu_in.resume |=> state_reg == DSB_RUN && !debug_status_control[BIT_ACTIVE])
        else $error("resume did not leave halt");
    wait_entry_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        state_reg == DSB_RUN && cpu_in.wait_stop && !halt_req_out |=> state_reg == DSB_STOP)
        else $error("wait or stop not tracked");
    run_ws_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        state_reg == DSB_RUN |-> !debug_status_control[BIT_WAIT_STOP])
        else $error("wait flag set while running");
    tag_halt_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        tag_pending_reg && cpu_in.tagged_at_end && background_permit_reg
        && state_reg == DSB_RUN |-> halt_req_out)
        else $error("tagged opcode executed");
    tag_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !breakpoint_enable_reg |=> !tag_pending_reg)
        else $error("tag kept while disabled");
    wsf_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        halted && cpu_in.resume && !cpu_in.mem_cmd_conflict |=> !wait_stop_failure_reg)
        else $error("failure flag not cleared");

    cov_force_c: cover property (@(posedge sys_clk_in) force_req ##1 halted);
    cov_wake_c:  cover property (@(posedge sys_clk_in) wake_out);
    cov_swi_c:   cover property (@(posedge sys_clk_in) swi_req_out);
    cov_tag_c:   cover property (@(posedge sys_clk_in) tag_pending_reg && cpu_in.tagged_at_end ##1 halted);
    cov_read_c:  cover property (@(posedge sys_clk_in) rd_bkpt ##1 rsp_out.valid);

endmodule // dsb_debug_ctl

/* hw/dsb_pkg.sv */
package dsb_pkg;

    // ***************************************************************
    // Status/control bit positions
    // ***************************************************************
    localparam int BIT_PERMIT     = 7;
    localparam int BIT_ACTIVE     = 6;
    localparam int BIT_BKPT_EN    = 5;
    localparam int BIT_FORCE_TAG  = 4;
    localparam int BIT_CLK_SEL    = 3;
    localparam int BIT_WAIT_STOP  = 2;
    localparam int BIT_WS_FAIL    = 1;
    localparam int BIT_DV_FAIL    = 0;

    // ***************************************************************
    // Reset values
    // ***************************************************************
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [15:0] BKPT_RESET = 16'h0000;

    // Debug command codes on the serial command port.
    typedef enum logic [2:0] {
        DSB_CMD_NONE       = 3'h0,
        DSB_CMD_READ_STAT  = 3'h1,
        DSB_CMD_WRITE_CTRL = 3'h2,
        DSB_CMD_BREAKPOINT_READ_COMMAND  = 3'h3,
        DSB_CMD_BREAKPOINT_WRITE_COMMAND = 3'h4,
        DSB_CMD_BACKGROUND = 3'h5
    } dsb_cmd_e;

    // CPU run state, Gray coded along run -> halted -> run and run -> stopped.
    typedef enum logic [1:0] {
        DSB_RUN  = 2'b00,
        DSB_HALT = 2'b01,
        DSB_STOP = 2'b10
    } dsb_state_e;

    typedef struct packed {
        dsb_cmd_e    cmd;
        logic [15:0] data;
    } dsb_cmd_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } dsb_rsp_s;

    // CPU side observations.
    typedef struct packed {
        logic [15:0] addr;
        logic        opcode_fetch;
        logic        inst_boundary;
        logic        tagged_at_end;
        logic        wait_stop;
        logic        mem_cmd_conflict;
        logic        resume;
    } dsb_cpu_s;

endpackage

/* hw/dsb_bkpt_match.sv */
`timescale 1ns/100ps
module dsb_bkpt_match (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        enable_in,
    input  wire logic        force_sel_in,
    input  wire logic [15:0] match_addr_in,
    input  wire logic [15:0] cpu_addr_in,
    input  wire logic        opcode_fetch_in,
    input  wire logic        boundary_in,
    input  wire logic        halted_in,
    output logic             force_req_out,
    output logic             tag_out
);
    import dsb_pkg::*;

    logic hit;
    logic pending_reg;

    assign hit = enable_in && (cpu_addr_in == match_addr_in);

    // A force match waits for the next instruction boundary.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || halted_in || !enable_in) begin
            pending_reg <= 1'b0;
        end else if (hit && force_sel_in) begin
            pending_reg <= 1'b1;
        end else if (boundary_in) begin
            pending_reg <= 1'b0;
        end
    end

    assign force_req_out = pending_reg && boundary_in && enable_in;
    assign tag_out       = hit && !force_sel_in && opcode_fetch_in;

    force_pend_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (hit && force_sel_in && !halted_in) ##1 (boundary_in && enable_in) |-> force_req_out)
        else $error("force match did not reach the boundary");

endmodule // dsb_bkpt_match

/* testbench/dsb_host_model.sv */
`timescale 1ns/100ps
// ***************************************************************
// Debug host model
// ***************************************************************
module dsb_host_model (
    input  wire logic              sys_clk_in,
    input  wire dsb_pkg::dsb_rsp_s rsp_in,
    output dsb_pkg::dsb_cmd_s      cmd_out
);
    import dsb_pkg::*;

    initial cmd_out = {DSB_CMD_NONE, 16'hFFFF};

    // One command for one clock; released data shows the inverse value.
    task automatic send(input dsb_cmd_e c, input logic [15:0] d);
        @(negedge sys_clk_in);
        cmd_out = {c, d};
        @(negedge sys_clk_in);
        cmd_out = {DSB_CMD_NONE, ~d};
    endtask

    // The answer stands for the one cycle after the command is taken.
    task automatic read(input dsb_cmd_e c, output logic [16:0] r);
        send(c, 16'h0000);
        r = {rsp_in.valid, rsp_in.data};
    endtask
endmodule // dsb_host_model

/* testbench/debug_status_breakpoint_ctl_tb_top.sv */
`timescale 1ns/100ps
module debug_status_breakpoint_ctl_tb_top;
    import dsb_pkg::*;

    logic     sys_clk_in;
    logic     rst_n_in;
    dsb_cmd_s cmd;
    dsb_cpu_s cpu;
    dsb_rsp_s rsp;
    logic     halt;
    logic     software_interrupt_instruction;
    logic     wake;
    logic     clk_sel;
    int       fails;
    int       compares;
    int       hc;
    int       sc;
    int       wc;

    dsb_debug_ctl dsb_debug_ctl_inst (
        .sys_clk_in            (sys_clk_in),
        .rst_n_in              (rst_n_in),
        .cmd_in                (cmd),
        .cpu_in                (cpu),
        .rsp_out               (rsp),
        .halt_req_out          (halt),
        .swi_req_out           (software_interrupt_instruction),
        .wake_out              (wake),
        .comm_clock_select_out (clk_sel)
    );

    dsb_host_model dsb_host_model_inst (
        .sys_clk_in (sys_clk_in),
        .rsp_in     (rsp),
        .cmd_out    (cmd)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // Counts the one-cycle request pulses seen at each rising edge.
    always @(posedge sys_clk_in) begin
        if (halt === 1'b1) hc++;
        if (software_interrupt_instruction === 1'b1) sc++;
        if (wake === 1'b1) wc++;
    end

    // ***************************************************************
    // Checking tasks
    // ***************************************************************
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stat(input logic [7:0] exp);
        logic [16:0] r;
        dsb_host_model_inst.read(DSB_CMD_READ_STAT, r);
        chk("status", {9'h100, exp}, r);
    endtask

    task automatic rbk(input logic [15:0] exp);
        logic [16:0] r;
        dsb_host_model_inst.read(DSB_CMD_BREAKPOINT_READ_COMMAND, r);
        chk("breakpoint", {1'b1, exp}, r);
    endtask

    task automatic wr(input dsb_cmd_e c, input logic [15:0] d);
        dsb_host_model_inst.send(c, d);
    endtask

    // Drives one cycle of CPU events; the wait level is kept afterwards.
    task automatic cpu_do(input logic [21:0] v);
        @(negedge sys_clk_in);
        cpu = v;
        @(negedge sys_clk_in);
        cpu = {v[21:6], 3'b000, v[2], 2'b00};
    endtask

    task automatic pulses(input logic [3:0] h, input logic [3:0] s, input logic [3:0] w);
        chk("pulse counts", {5'h00, h, s, w}, {5'h00, hc[3:0], sc[3:0], wc[3:0]});
    endtask

    task automatic test_done;
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #20000;
        fails++;
        test_done();
    end

    // ***************************************************************
    // Test sequence
    // ***************************************************************
    initial begin
        fails = 0;
        compares = 0;
        hc = 0;
        sc = 0;
        wc = 0;
        rst_n_in = 1'b0;
        cpu = '0;
        repeat (8) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        stat(8'h00);
        rbk(16'h0000);
        wr(DSB_CMD_WRITE_CTRL, 16'h00FF);
        stat(8'hB8);
        chk("clock select", 17'h00001, {16'h0000, clk_sel});
        wr(DSB_CMD_BREAKPOINT_WRITE_COMMAND, 16'hA55A);
        rbk(16'hA55A);
        cpu_do({16'hA55A, 6'h00});
        cpu_do({16'hA55A, 6'h10});
        pulses(4'h1, 4'h0, 4'h0);
        stat(8'hF8);
        wr(DSB_CMD_WRITE_CTRL, 16'h0038);
        stat(8'hF8);
        cpu_do({16'h0000, 6'h01});
        stat(8'hB8);
        wr(DSB_CMD_WRITE_CTRL, 16'h0088);
        cpu_do({16'hA55A, 6'h00});
        cpu_do({16'hA55A, 6'h18});
        pulses(4'h1, 4'h0, 4'h0);
        wr(DSB_CMD_WRITE_CTRL, 16'h00A8);
        cpu_do({16'hA55A, 6'h20});
        cpu_do({16'h0000, 6'h08});
        pulses(4'h2, 4'h0, 4'h0);
        stat(8'hE8);
        cpu_do({16'h0000, 6'h01});
        cpu_do({16'h0000, 6'h04});
        stat(8'hAC);
        cpu_do({16'h0000, 6'h06});
        stat(8'hAE);
        wr(DSB_CMD_BACKGROUND, 16'h0000);
        pulses(4'h3, 4'h0, 4'h1);
        cpu_do({16'h0000, 6'h00});
        stat(8'hEE);
        cpu_do({16'h0000, 6'h01});
        stat(8'hA8);
        @(negedge sys_clk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        stat(8'h00);
        wr(DSB_CMD_WRITE_CTRL, 16'h0030);
        wr(DSB_CMD_BACKGROUND, 16'h0000);
        pulses(4'h3, 4'h0, 4'h1);
        cpu_do({16'h0000, 6'h10});
        pulses(4'h3, 4'h1, 4'h1);
        stat(8'h30);
        test_done();
    end
endmodule // debug_status_breakpoint_ctl_tb_top
